/* verilog/pwm_pkg.sv */
// package: register map, field layout and reset values of the pulse width modulator
package pwm_pkg;
   localparam logic [7:0] PWM_OFF_IDENT = 8'h00;
   localparam logic [7:0] PWM_OFF_CONTROL = 8'h04;
   localparam logic [7:0] PWM_OFF_CFG = 8'h08;
   localparam logic [7:0] PWM_OFF_START = 8'h0c;
   localparam logic [7:0] PWM_OFF_REPEAT = 8'h10;
   localparam logic [7:0] PWM_OFF_PER = 8'h14;
   localparam logic [7:0] PWM_OFF_PH1 = 8'h18;
   localparam logic [7:0] PWM_OFF_STAT = 8'h1c;
   localparam logic [7:0] PWM_OFF_MASK = 8'h20;
   // identification value, arbitrary
   localparam logic [31:0] PWM_IDENT_VAL = 32'h0001_0100;
   // waveform_config fields
   localparam int PWM_CFG_MODE_LO = 0;
   localparam int PWM_CFG_TRIG_LO = 2;
   localparam int PWM_CFG_EDGE_BIT = 4;
   localparam int PWM_CFG_P1OUT_BIT = 5;
   localparam int PWM_CFG_INACT_BIT = 6;
   localparam int PWM_CTRL_EN_BIT = 0;
   localparam logic [1:0] PWM_MODE_OFF = 2'h0;
   localparam logic [1:0] PWM_MODE_ONE = 2'h1;
   localparam logic [1:0] PWM_MODE_CONT = 2'h2;
   localparam logic [1:0] PWM_TRIG_SW = 2'h0;
   localparam logic [1:0] PWM_TRIG_EVT = 2'h1;
   localparam logic [1:0] PWM_TRIG_VSYNC = 2'h2;
   localparam logic [31:0] PWM_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] PWM_PER_RST = 32'h0000_0000;
   localparam logic [31:0] PWM_PH1_RST = 32'h0000_0000;
   // status bits
   localparam int PWM_ST_PERIOD = 0;
   localparam int PWM_ST_DONE = 1;
   localparam int PWM_ST_W = 2;
   typedef enum logic [2:0] {
      PWM_IDLE = 3'b001,
      PWM_ARMED = 3'b010,
      PWM_RUN = 3'b100
   } pwm_state_type;
endpackage

/* verilog/pwm_edge.sv */
// edge detector for the hardware trigger inputs
`timescale 1ns/10ps
module pwm_edge (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // sampled level and selection
   input wire logic level,
   input wire logic falling,
   // detected edge pulse
   output logic edge_seen
);
   typedef struct packed {
      logic primed;
      logic prev;
   } pwm_edge_type;
   pwm_edge_type s_r, s_nxt;
   always_comb begin
      s_nxt.primed = 1'b1;
      s_nxt.prev = level;
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   // no edge until one level has been seen after reset, whatever the pin idles at
   assign edge_seen = s_r.primed & (falling ? (s_r.prev & ~level) : (~s_r.prev & level));
endmodule

/* verilog/pwm_top.sv */
// pulse width modulator with AXI4-Lite register slave
//
// Functional notes
// - 32-bit period counter, comparator ends first phase
// - one-shot emits repeat plus one periods
// - mode selects continuous or one-shot
// - period and phase registers are double buffered
// - hardware event edge starts one-shot
// - video sync can start one-shot
// - idle output shows configured inactive level
// - interrupt and dma sync from waveform
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
module pwm_top #(
   parameter int CNT_W = 32,
   parameter int REP_W = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // triggers
   input wire logic hw_event,
   input wire logic image_sensor_port_vsync,
   // outputs
   output logic pwm_out,
   output logic irq,
   output logic dma_sync_target
);
   import pwm_pkg::*;

   typedef struct packed {
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic enable;
      logic [31:0] cfg;
      logic [REP_W-1:0] rep;
      logic [CNT_W-1:0] per_sh;
      logic [CNT_W-1:0] ph1_sh;
      logic [CNT_W-1:0] per_act;
      logic [CNT_W-1:0] ph1_act;
      logic [CNT_W-1:0] cnt;
      logic [REP_W-1:0] left;
      logic out;
      logic dma;
      logic [PWM_ST_W-1:0] stat;
      logic [PWM_ST_W-1:0] mask;
      pwm_state_type st;
   } pwm_regs_type;

   pwm_regs_type r_r, r_nxt;
   logic evt_edge, vs_edge, wr_fire, sw_start, trig, period_end;
   logic [PWM_ST_W-1:0] ev_set;
   logic [1:0] mode, tsel;

   assign mode = r_r.cfg[PWM_CFG_MODE_LO +: 2];
   assign tsel = r_r.cfg[PWM_CFG_TRIG_LO +: 2];

   pwm_edge u_evt (
      .sys_clk(sys_clk),
      .rst(rst),
      .level(hw_event),
      .falling(r_r.cfg[PWM_CFG_EDGE_BIT]),
      .edge_seen(evt_edge)
   );
   pwm_edge u_vs (
      .sys_clk(sys_clk),
      .rst(rst),
      .level(image_sensor_port_vsync),
      .falling(r_r.cfg[PWM_CFG_EDGE_BIT]),
      .edge_seen(vs_edge)
   );

   assign wr_fire = r_r.aw_got & r_r.w_got & ~r_r.bvalid;
   // start write is a pulse, no storage
   assign sw_start = wr_fire & (r_r.aw_addr == PWM_OFF_START) & r_r.w_data[0];
   assign trig = (tsel == PWM_TRIG_SW) ? sw_start :
                 (tsel == PWM_TRIG_EVT) ? evt_edge :
                 (tsel == PWM_TRIG_VSYNC) ? vs_edge : 1'b0;
   // period ends when counter reaches period
   assign period_end = (r_r.st == PWM_RUN) && (r_r.cnt >= r_r.per_act);

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return res;
   endfunction

   always_comb begin
      r_nxt = r_r;
      ev_set = '0;
      // write channel capture
      if (s_axi_awvalid && s_axi_awready) begin
         r_nxt.aw_got = 1'b1;
         r_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         r_nxt.w_got = 1'b1;
         r_nxt.w_data = s_axi_wdata;
         r_nxt.w_strb = s_axi_wstrb;
      end
      if (wr_fire) begin
         r_nxt.aw_got = 1'b0;
         r_nxt.w_got = 1'b0;
         r_nxt.bvalid = 1'b1;
         r_nxt.bresp = 2'b00;
         case (r_r.aw_addr)
            PWM_OFF_CONTROL: begin
               r_nxt.enable = r_r.w_data[PWM_CTRL_EN_BIT];
            end
            PWM_OFF_CFG: begin
               r_nxt.cfg = wmerge(r_r.cfg, r_r.w_data, r_r.w_strb);
            end
            PWM_OFF_REPEAT: begin
               r_nxt.rep = REP_W'(wmerge(32'(r_r.rep), r_r.w_data, r_r.w_strb));
            end
            PWM_OFF_PER: begin
               r_nxt.per_sh = CNT_W'(wmerge(32'(r_r.per_sh), r_r.w_data, r_r.w_strb));
            end
            PWM_OFF_PH1: begin
               r_nxt.ph1_sh = CNT_W'(wmerge(32'(r_r.ph1_sh), r_r.w_data, r_r.w_strb));
            end
            PWM_OFF_MASK: begin
               r_nxt.mask = r_r.w_data[PWM_ST_W-1:0];
            end
            PWM_OFF_STAT: begin
               r_nxt.stat = r_r.stat & ~r_r.w_data[PWM_ST_W-1:0];
            end
            PWM_OFF_IDENT, PWM_OFF_START: begin
               r_nxt.bresp = 2'b00;
            end
            default: begin
               r_nxt.bresp = 2'b10;
            end
         endcase
      end
      if (r_r.bvalid && s_axi_bready) begin
         r_nxt.bvalid = 1'b0;
      end
      // read channel
      if (s_axi_arvalid && s_axi_arready) begin
         r_nxt.rvalid = 1'b1;
         r_nxt.rresp = 2'b00;
         case (s_axi_araddr)
            PWM_OFF_IDENT: r_nxt.rdata = PWM_IDENT_VAL;
            PWM_OFF_CONTROL: r_nxt.rdata = 32'(r_r.enable);
            PWM_OFF_CFG: r_nxt.rdata = r_r.cfg;
            PWM_OFF_START: r_nxt.rdata = 32'h0000_0000;
            PWM_OFF_REPEAT: r_nxt.rdata = 32'(r_r.rep);
            PWM_OFF_PER: r_nxt.rdata = 32'(r_r.per_sh);
            PWM_OFF_PH1: r_nxt.rdata = 32'(r_r.ph1_sh);
            PWM_OFF_STAT: r_nxt.rdata = {29'h0, r_r.st == PWM_RUN, r_r.stat};
            PWM_OFF_MASK: r_nxt.rdata = 32'(r_r.mask);
            default: begin
               r_nxt.rdata = 32'h0000_0000;
               r_nxt.rresp = 2'b10;
            end
         endcase
      end else if (r_r.rvalid && s_axi_rready) begin
         r_nxt.rvalid = 1'b0;
      end
      // generator
      r_nxt.dma = 1'b0;
      case (r_r.st)
         PWM_IDLE: begin
            r_nxt.cnt = '0;
            if (r_r.enable && mode == PWM_MODE_CONT) begin
               r_nxt.st = PWM_RUN;
               r_nxt.per_act = r_r.per_sh;
               r_nxt.ph1_act = r_r.ph1_sh;
            end else if (r_r.enable && mode == PWM_MODE_ONE) begin
               r_nxt.st = PWM_ARMED;
            end
         end
         PWM_ARMED: begin
            if (!r_r.enable || mode != PWM_MODE_ONE) begin
               r_nxt.st = PWM_IDLE;
            end else if (trig) begin
               r_nxt.st = PWM_RUN;
               r_nxt.cnt = '0;
               r_nxt.left = r_r.rep;
               r_nxt.per_act = r_r.per_sh;
               r_nxt.ph1_act = r_r.ph1_sh;
            end
         end
         PWM_RUN: begin
            r_nxt.cnt = r_r.cnt + CNT_W'(1);
            if (!r_r.enable || mode == PWM_MODE_OFF) begin
               r_nxt.st = PWM_IDLE;
            end else if (period_end) begin
               r_nxt.cnt = '0;
               // while running, shadows load only at period boundary
               r_nxt.per_act = r_r.per_sh;
               r_nxt.ph1_act = r_r.ph1_sh;
               // period end drives dma sync and status
               r_nxt.dma = 1'b1;
               ev_set[PWM_ST_PERIOD] = 1'b1;
               // stop after repeat plus one periods
               if (mode == PWM_MODE_ONE) begin
                  if (r_r.left == '0) begin
                     r_nxt.st = PWM_ARMED;
                     ev_set[PWM_ST_DONE] = 1'b1;
                  end else begin
                     r_nxt.left = r_r.left - REP_W'(1);
                  end
               end
            end
         end
         default: begin
            r_nxt.st = PWM_IDLE;
         end
      endcase
      // first phase while counter below comparator value
      if (r_nxt.st == PWM_RUN) begin
         r_nxt.out = (r_nxt.cnt < r_nxt.ph1_act) ? r_r.cfg[PWM_CFG_P1OUT_BIT] : ~r_r.cfg[PWM_CFG_P1OUT_BIT];
      end else begin
         r_nxt.out = r_r.cfg[PWM_CFG_INACT_BIT];
      end
      // set wins over clear
      r_nxt.stat = r_nxt.stat | ev_set;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r_r <= '0;
         r_r.st <= PWM_IDLE;
         r_r.cfg <= PWM_CFG_RST;
         r_r.per_sh <= PWM_PER_RST;
         r_r.ph1_sh <= PWM_PH1_RST;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign s_axi_awready = ~r_r.aw_got & ~r_r.bvalid;
   assign s_axi_wready = ~r_r.w_got & ~r_r.bvalid;
   assign s_axi_bvalid = r_r.bvalid;
   assign s_axi_bresp = r_r.bresp;
   assign s_axi_arready = ~r_r.rvalid;
   assign s_axi_rvalid = r_r.rvalid;
   assign s_axi_rdata = r_r.rdata;
   assign s_axi_rresp = r_r.rresp;
   assign pwm_out = r_r.out;
   assign dma_sync_target = r_r.dma;
   // level interrupt from masked sticky status
   assign irq = |(r_r.stat & r_r.mask);

   // assertions
   // inactive level when not running
   idle_level_a: assert property (@(posedge sys_clk) disable iff (rst)
      (r_r.st != PWM_RUN) |=> (pwm_out == $past(r_r.cfg[PWM_CFG_INACT_BIT])) || (r_r.st == PWM_RUN))
      else $error("idle output not at inactive level");
   dma_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
      period_end && r_r.enable && mode != PWM_MODE_OFF |=> dma_sync_target ##1 (!dma_sync_target || $past(period_end)))
      else $error("dma sync missing at period end");
   period_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
      period_end && r_r.enable && mode != PWM_MODE_OFF |=> r_r.stat[PWM_ST_PERIOD])
      else $error("period flag not set at period end");
   oneshot_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
      period_end && mode == PWM_MODE_ONE && r_r.enable && r_r.left == '0 |=> r_r.st == PWM_ARMED && r_r.stat[PWM_ST_DONE])
      else $error("one-shot did not stop after last period");
   oneshot_count_a: assert property (@(posedge sys_clk) disable iff (rst)
      period_end && mode == PWM_MODE_ONE && r_r.enable && r_r.left != '0 |=> r_r.left == $past(r_r.left) - REP_W'(1))
      else $error("repeat count not decremented");
   shadow_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      r_r.st == PWM_RUN && !period_end |=> r_r.per_act == $past(r_r.per_act) || r_r.st != PWM_RUN)
      else $error("active period changed mid period");
   sw_start_a: assert property (@(posedge sys_clk) disable iff (rst)
      r_r.st == PWM_ARMED && mode == PWM_MODE_ONE && r_r.enable && tsel == PWM_TRIG_SW && sw_start |=> r_r.st == PWM_RUN)
      else $error("software start did not begin run");
   evt_start_a: assert property (@(posedge sys_clk) disable iff (rst)
      r_r.st == PWM_ARMED && mode == PWM_MODE_ONE && r_r.enable && tsel == PWM_TRIG_EVT && evt_edge |=> r_r.st == PWM_RUN)
      else $error("event edge did not begin run");
   vs_start_a: assert property (@(posedge sys_clk) disable iff (rst)
      r_r.st == PWM_ARMED && mode == PWM_MODE_ONE && r_r.enable && tsel == PWM_TRIG_VSYNC && vs_edge |=> r_r.st == PWM_RUN)
      else $error("video sync edge did not begin run");
   reset_idle_a: assert property (@(posedge sys_clk)
      rst |=> r_r.st == PWM_IDLE && r_r.cnt == '0 && !pwm_out)
      else $error("not idle after reset");
   run_cov: cover property (@(posedge sys_clk) disable iff (rst) r_r.st == PWM_ARMED ##1 r_r.st == PWM_RUN);
   done_cov: cover property (@(posedge sys_clk) disable iff (rst) $rose(r_r.stat[PWM_ST_DONE]));
   cont_cov: cover property (@(posedge sys_clk) disable iff (rst) period_end && mode == PWM_MODE_CONT);
endmodule

/* verif/pwm_load_model.sv */
// observer of the waveform pin: counts pulses and measures high and low run lengths
`timescale 1ns/10ps
module pwm_load_model (
   // clock and measurement clear
   input wire logic sys_clk,
   input wire logic clr,
   // waveform pin
   input wire logic drive_in,
   // measurements
   output int pulses,
   output int hi_len,
   output int lo_len
);
   logic prev;
   int run;
   always @(posedge sys_clk) begin
      prev <= drive_in;
      if (clr) begin
         pulses <= 0;
         hi_len <= 0;
         lo_len <= 0;
         run <= 1;
      end else if (drive_in !== prev) begin
         if (prev === 1'b1) hi_len <= run;
         else lo_len <= run;
         if (drive_in === 1'b1) pulses <= pulses + 1;
         run <= 1;
      end else begin
         run <= run + 1;
      end
   end
endmodule

/* verif/pulse_width_modulator_tb.sv */
// self-checking bench of the pulse width modulator
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module pulse_width_modulator_tb;
   import pwm_pkg::*;
   typedef struct {logic [7:0] a; bit wr; logic [31:0] d; logic [31:0] e;} pwm_row_type;
   logic sys_clk = 0;
   logic rst = 1;
   logic [7:0] awaddr = 0, araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, pwm_out, irq, dma;
   logic [31:0] wdata = 0, rdata, rd;
   logic [3:0] wstrb = 0;
   logic [1:0] bresp, rresp, rs;
   logic hw_event = 0, vsync = 0, clr = 1;
   int pulses, hi_len, lo_len, dma_cnt, cyc, bad_count, num_checks;
   pwm_row_type rows [9] = '{'{PWM_OFF_IDENT, 0, 0, PWM_IDENT_VAL}, '{PWM_OFF_CFG, 0, 0, PWM_CFG_RST},
      '{PWM_OFF_PER, 0, 0, PWM_PER_RST}, '{PWM_OFF_PH1, 0, 0, PWM_PH1_RST},
      '{PWM_OFF_PER, 1, 32'hdead_beef, 32'hdead_beef}, '{PWM_OFF_PH1, 1, 32'h0000_0100, 32'h0000_0100},
      '{PWM_OFF_REPEAT, 1, 32'h0000_01a5, 32'h0000_00a5}, '{PWM_OFF_START, 1, 32'h0000_0000, 32'h0000_0000},
      '{PWM_OFF_MASK, 1, 32'h0000_0003, 32'h0000_0003}};
   pwm_top pwm_top_inst (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hw_event(hw_event),
      .image_sensor_port_vsync(vsync), .pwm_out(pwm_out), .irq(irq), .dma_sync_target(dma));
   pwm_load_model pwm_load_model_inst (.sys_clk(sys_clk), .clr(clr), .drive_in(pwm_out),
      .pulses(pulses), .hi_len(hi_len), .lo_len(lo_len));
   always #5 sys_clk = ~sys_clk;
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // cycle ceiling cuts a hang short
   always @(posedge sys_clk) begin
      cyc++;
      if (dma === 1'b1) dma_cnt++;
      if (cyc == 8000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit aw, w;
      aw = 0;
      w = 0;
      @(posedge sys_clk);
      awaddr <= a;
      awvalid <= 1;
      wdata <= d;
      wstrb <= 4'hf;
      wvalid <= 1;
      bready <= 1;
      while (!(aw && w)) begin
         @(posedge sys_clk);
         if (!aw && awready === 1'b1) begin
            awvalid <= 0;
            aw = 1;
         end
         if (!w && wready === 1'b1) begin
            wvalid <= 0;
            w = 1;
         end
      end
      do @(posedge sys_clk); while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 0;
   endtask
   task automatic rdt(input logic [7:0] a);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge sys_clk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge sys_clk); while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic clear_meas;
      @(posedge sys_clk);
      clr <= 1;
      @(posedge sys_clk);
      clr <= 0;
      dma_cnt = 0;
   endtask
   function automatic logic [31:0] cfgw(logic [1:0] m, logic [1:0] t, logic e, logic p, logic i);
      return {25'h0, i, p, e, t, m};
   endfunction
   // reprogram with the generator disabled, then enable and arm
   task automatic setup(input logic [31:0] c, input logic [31:0] r, input logic [31:0] p, input logic [31:0] h);
      wr(PWM_OFF_CONTROL, 32'h0);
      wr(PWM_OFF_PER, p);
      wr(PWM_OFF_PH1, h);
      wr(PWM_OFF_REPEAT, r);
      wr(PWM_OFF_CFG, c);
      wr(PWM_OFF_STAT, 32'h3);
      wr(PWM_OFF_CONTROL, 32'h1);
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 0;
      @(posedge sys_clk);
      `CHK("pwm_out", 1'b0, pwm_out)
      `CHK("irq", 1'b0, irq)
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].a, rows[i].d);
         rdt(rows[i].a);
         `CHK("reg", rows[i].e, rd)
         `CHK("rresp", 2'h0, rs)
      end
      wr(8'h40, 32'h1);
      `CHK("bresp", 2'h2, rs)
      rdt(8'h40);
      `CHK("rresp", 2'h2, rs)
      setup(cfgw(PWM_MODE_CONT, PWM_TRIG_SW, 0, 1, 0), 0, 4, 2);
      clear_meas();
      idle(40);
      `CHK("hi_len", 2, hi_len)
      `CHK("lo_len", 3, lo_len)
      // new phase length applies at period end
      wr(PWM_OFF_PH1, 32'h3);
      clear_meas();
      idle(30);
      `CHK("hi_len", 3, hi_len)
      `CHK("lo_len", 2, lo_len)
      // software one-shot of repeat plus one periods
      setup(cfgw(PWM_MODE_ONE, PWM_TRIG_SW, 0, 1, 0), 2, 3, 1);
      clear_meas();
      wr(PWM_OFF_START, 32'h1);
      `CHK("bresp", 2'h0, rs)
      idle(60);
      `CHK("pulses", 3, pulses)
      `CHK("dma", 3, dma_cnt)
      `CHK("hi_len", 1, hi_len)
      `CHK("pwm_out", 1'b0, pwm_out)
      rdt(PWM_OFF_STAT);
      `CHK("done", 1'b1, rd[PWM_ST_DONE])
      wr(PWM_OFF_MASK, 32'h2);
      `CHK("irq", 1'b1, irq)
      wr(PWM_OFF_STAT, 32'h3);
      `CHK("irq", 1'b0, irq)
      rdt(PWM_OFF_STAT);
      `CHK("stat", 2'h0, rd[1:0])
      wr(PWM_OFF_MASK, 32'h0);
      wr(PWM_OFF_START, 32'h1);
      idle(40);
      `CHK("irq", 1'b0, irq)
      `CHK("pulses", 6, pulses)
      // edge-selected hardware and video sync triggers
      for (int t = 1; t < 3; t++) begin
         for (int e = 0; e < 2; e++) begin
            if (t == 1) hw_event <= e[0];
            else vsync <= e[0];
            setup(cfgw(PWM_MODE_ONE, t[1:0], e[0], 1, 0), 0, 3, 1);
            clear_meas();
            idle(10);
            `CHK("pulses", 0, pulses)
            if (t == 1) hw_event <= !e[0];
            else vsync <= !e[0];
            idle(30);
            `CHK("pulses", 1, pulses)
            if (t == 1) hw_event <= e[0];
            else vsync <= e[0];
            idle(30);
            `CHK("pulses", 1, pulses)
         end
      end
      setup(cfgw(PWM_MODE_OFF, PWM_TRIG_SW, 0, 1, 1), 0, 3, 1);
      idle(5);
      `CHK("pwm_out", 1'b1, pwm_out)
      wr(PWM_OFF_CFG, cfgw(PWM_MODE_CONT, PWM_TRIG_SW, 0, 1, 1));
      idle(3);
      rst <= 1;
      idle(3);
      rst <= 0;
      @(posedge sys_clk);
      `CHK("pwm_out", 1'b0, pwm_out)
      rdt(PWM_OFF_CFG);
      `CHK("cfg", PWM_CFG_RST, rd)
      rdt(PWM_OFF_STAT);
      `CHK("stat", 32'h0000_0000, rd)
      test_done();
   end
endmodule
